/* File: hw/pfs_pkg.sv */
// package: register map, field positions and pin constants of the function-select block
package pfs_pkg;
  localparam int NREG = 18; // select registers, pins p2.1 .. p4.2
  localparam int IDX_W = 5; // width of a register slot number
  localparam int ADDR_W = 18; // byte address width on the bus

  // register indices; byte address is four times the index
  localparam logic [15:0] P2_1_FUNCTION_SELECT = 16'ha071;
  localparam logic [15:0] P2_2_FUNCTION_SELECT = 16'ha072;
  localparam logic [15:0] P2_3_FUNCTION_SELECT = 16'ha073;
  localparam logic [15:0] P2_4_FUNCTION_SELECT = 16'ha074;
  localparam logic [15:0] P2_5_FUNCTION_SELECT = 16'ha075;
  localparam logic [15:0] P2_6_FUNCTION_SELECT = 16'ha076;
  localparam logic [15:0] P2_7_FUNCTION_SELECT = 16'ha077;
  localparam logic [15:0] P3_0_FUNCTION_SELECT = 16'ha078;
  localparam logic [15:0] P3_1_FUNCTION_SELECT = 16'ha079;
  localparam logic [15:0] P3_2_FUNCTION_SELECT = 16'ha07a;
  localparam logic [15:0] P3_3_FUNCTION_SELECT = 16'ha07b;
  localparam logic [15:0] P3_4_FUNCTION_SELECT = 16'ha07c;
  localparam logic [15:0] P3_5_FUNCTION_SELECT = 16'ha07d;
  localparam logic [15:0] P3_6_FUNCTION_SELECT = 16'ha07e;
  localparam logic [15:0] P3_7_FUNCTION_SELECT = 16'ha07f;
  localparam logic [15:0] P4_0_FUNCTION_SELECT = 16'ha0d0;
  localparam logic [15:0] P4_1_FUNCTION_SELECT = 16'ha0d1;
  localparam logic [15:0] P4_2_FUNCTION_SELECT = 16'ha0d2;
  // slot order used everywhere: slot n is pin n of the list above
  localparam logic [15:0] REG_INDEX [NREG] = '{
    P2_1_FUNCTION_SELECT, P2_2_FUNCTION_SELECT, P2_3_FUNCTION_SELECT, P2_4_FUNCTION_SELECT,
    P2_5_FUNCTION_SELECT, P2_6_FUNCTION_SELECT, P2_7_FUNCTION_SELECT, P3_0_FUNCTION_SELECT,
    P3_1_FUNCTION_SELECT, P3_2_FUNCTION_SELECT, P3_3_FUNCTION_SELECT, P3_4_FUNCTION_SELECT,
    P3_5_FUNCTION_SELECT, P3_6_FUNCTION_SELECT, P3_7_FUNCTION_SELECT, P4_0_FUNCTION_SELECT,
    P4_1_FUNCTION_SELECT, P4_2_FUNCTION_SELECT};
  // implemented bits of each register
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'h03, 8'h03, 8'h83, 8'h03, 8'h03, 8'h01, 8'h01, 8'h03, 8'h03,
    8'h83, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h0f, 8'h03, 8'h01};
  localparam logic [7:0] SEL_RESET = 8'h00; // value after reset

  // field positions
  localparam int GENERAL_IO_SELECT_BIT = 0;
  localparam int PIN_FUNCTION_SELECT_BIT = 1;
  localparam int CONSUMER_CONTROL_WAKE_SELECT_BIT = 2;
  localparam int CAN_RECEIVE_PIN_SELECT_BIT = 3;
  localparam int VOLTAGE_DAC_OUTPUT_SELECT_BIT = 7;

  // slots with special side logic
  localparam int PIN_P2_1 = 1 - 1;
  localparam int PIN_P2_3 = 2;
  localparam int PIN_P3_2 = 9;
  localparam int PIN_P3_4 = 11;
  localparam int PIN_P4_0 = 15;

  // pins whose peripheral may drive the pad
  localparam logic [NREG-1:0] FN_OUT_CAP = 18'h1f792;
  // level a peripheral input sees while its pin is not selected
  localparam logic [NREG-1:0] FN_IN_IDLE = 18'h18804;
  localparam logic LINE_IDLE = 1'b1; // idle level of interrupt and can lines

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/pfs_reg_if.sv */
// interface: access to the select-register store
`timescale 1ns/1ps
interface pfs_reg_if;
  logic wr_en; // write strobe
  logic [pfs_pkg::IDX_W-1:0] wr_idx; // slot written
  logic [7:0] wr_data; // byte written
  logic rd_en; // read strobe
  logic [pfs_pkg::IDX_W-1:0] rd_idx; // slot read
  logic [7:0] rd_data; // registered read byte
  logic [pfs_pkg::NREG-1:0][7:0] sel; // every select byte, live
  modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, sel);
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, sel);
endinterface

/* File: hw/pfs_regfile.sv */
// module: select-register store with masked writes and registered read
`timescale 1ns/1ps
module pfs_regfile (
  input wire logic clk,
  input wire logic rst_n,
  pfs_reg_if.store rif
);
  logic [pfs_pkg::NREG-1:0][7:0] sel_ff; // select bytes
  logic [7:0] rd_data_ff; // read port register

  // write port, unused bits never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < pfs_pkg::NREG; i++) begin
        sel_ff[i] <= pfs_pkg::SEL_RESET;
      end
    end else if (rif.wr_en && rif.wr_idx < pfs_pkg::IDX_W'(pfs_pkg::NREG)) begin
      sel_ff[rif.wr_idx] <= rif.wr_data & pfs_pkg::REG_MASK[rif.wr_idx];
    end
  end

  // read port, data valid the edge after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= pfs_pkg::SEL_RESET;
    end else if (rif.rd_en && rif.rd_idx < pfs_pkg::IDX_W'(pfs_pkg::NREG)) begin
      rd_data_ff <= sel_ff[rif.rd_idx];
    end
  end

  assign rif.sel = sel_ff;
  assign rif.rd_data = rd_data_ff;

  reset_clear_a: assert property (@(posedge clk) $rose(rst_n) |-> (sel_ff == '0))
    else $error("select registers not clear after reset");

  for (genvar k = 0; k < pfs_pkg::NREG; k++) begin : g_chk
    unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_ff[k] & ~pfs_pkg::REG_MASK[k]) == 8'h00)
      else $error("unused select bit is set");
    write_back_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rif.wr_en && rif.wr_idx == pfs_pkg::IDX_W'(k))
      |=> sel_ff[k] == ($past(rif.wr_data) & pfs_pkg::REG_MASK[k]))
      else $error("select register did not take written value");
  end
endmodule

/* File: hw/pfs_pin_cell.sv */
// module: one pad's output, enable and input routing
`timescale 1ns/1ps
module pfs_pin_cell #(
  parameter logic OUT_CAP = 1'b0,
  parameter logic IN_IDLE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_gpio,
  input wire logic sel_fn,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic fn_out,
  input wire logic fn_oe,
  input wire logic pad_in,
  output logic pad_out_ff,
  output logic pad_oe_n_ff,
  output logic gpio_in_ff,
  output logic fn_in_ff
);
  // peripheral wins over gpio if software breaks exclusivity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_ff <= 1'b0;
      pad_oe_n_ff <= 1'b1;
      gpio_in_ff <= 1'b0;
      fn_in_ff <= IN_IDLE;
    end else if (sel_fn) begin
      // peripheral owns pad
      pad_out_ff <= fn_out;
      pad_oe_n_ff <= ~(OUT_CAP & fn_oe);
      gpio_in_ff <= 1'b0;
      fn_in_ff <= pad_in;
    end else if (sel_gpio) begin
      pad_out_ff <= gpio_out;
      pad_oe_n_ff <= ~gpio_oe;
      gpio_in_ff <= pad_in;
      fn_in_ff <= IN_IDLE;
    end else begin
      pad_out_ff <= 1'b0;
      pad_oe_n_ff <= 1'b1;
      gpio_in_ff <= 1'b0;
      fn_in_ff <= IN_IDLE;
    end
  end

  gpio_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_gpio && !sel_fn) |=> (pad_oe_n_ff == !$past(gpio_oe) && gpio_in_ff == $past(pad_in)))
    else $error("gpio pin not following gpio controls");
  idle_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!sel_gpio && !sel_fn) |=> (pad_oe_n_ff && fn_in_ff == IN_IDLE && !gpio_in_ff))
    else $error("unselected pin driven or input not idle");
endmodule

/* File: hw/pfs_top.sv */
// module: function-select registers for pins p2.1 to p4.2 with bus slave and pad routing
`timescale 1ns/1ps
module pfs_top (
  input wire logic mclk,
  input wire logic nrst,
  // bus write address
  input wire logic [pfs_pkg::ADDR_W-1:0] axi_awaddr,
  input wire logic axi_awvalid,
  output logic axi_awready,
  // bus write data
  input wire logic [31:0] axi_wdata,
  input wire logic [3:0] axi_wstrb,
  input wire logic axi_wvalid,
  output logic axi_wready,
  // bus write response
  output logic [1:0] axi_bresp,
  output logic axi_bvalid,
  input wire logic axi_bready,
  // bus read address
  input wire logic [pfs_pkg::ADDR_W-1:0] axi_araddr,
  input wire logic axi_arvalid,
  output logic axi_arready,
  // bus read data
  output logic [31:0] axi_rdata,
  output logic [1:0] axi_rresp,
  output logic axi_rvalid,
  input wire logic axi_rready,
  // pads, one bit per slot
  input wire logic [pfs_pkg::NREG-1:0] pad_in,
  output logic [pfs_pkg::NREG-1:0] pad_out,
  output logic [pfs_pkg::NREG-1:0] pad_oe_n,
  // gpio controller side
  input wire logic [pfs_pkg::NREG-1:0] gpio_out,
  input wire logic [pfs_pkg::NREG-1:0] gpio_oe,
  output logic [pfs_pkg::NREG-1:0] gpio_in,
  // peripheral side, slot n serves pin n's function
  input wire logic [pfs_pkg::NREG-1:0] periph_out,
  input wire logic [pfs_pkg::NREG-1:0] periph_oe,
  output logic [pfs_pkg::NREG-1:0] periph_in,
  input wire logic spi_is_slave,
  // side functions
  output logic crystal_output_select,
  output logic [1:0] voltage_dac_output_select,
  output logic pin_interrupt_line_0_3,
  output logic pin_interrupt_line_0_2,
  output logic can_receive,
  output logic consumer_control_stop_wake,
  output logic consumer_control_wake_capable
);
  localparam int NREG = pfs_pkg::NREG; // slot count
  localparam int IDX_W = pfs_pkg::IDX_W; // slot number width
  localparam int ADDR_W = pfs_pkg::ADDR_W; // address width
  localparam int FN = pfs_pkg::PIN_FUNCTION_SELECT_BIT; // peripheral bit
  localparam int GIO = pfs_pkg::GENERAL_IO_SELECT_BIT; // gpio bit

  // reset synchroniser
  logic rst_meta_ff; // first stage
  logic rst_sync_ff; // second stage
  logic rst_n; // released reset for the block

  // pad input synchroniser
  logic [NREG-1:0] pad_meta_ff; // first stage
  logic [NREG-1:0] pad_sync_ff; // second stage

  // write channel state
  logic aw_full_ff; // address held
  logic awready_ff; // address ready
  logic [ADDR_W-1:0] aw_addr_ff; // held address
  logic w_full_ff; // data held
  logic wready_ff; // data ready
  logic [7:0] w_data_ff; // held low byte
  logic w_lane0_ff; // low byte lane enabled
  logic bvalid_ff; // response pending
  logic [1:0] bresp_ff; // response code

  // read channel state
  logic arready_ff; // address ready
  logic rd_wait_ff; // store read in flight
  logic ar_hit_ff; // read address mapped
  logic rvalid_ff; // data pending
  logic [31:0] rdata_ff; // read data
  logic [1:0] rresp_ff; // read response

  // side function flops
  logic crystal_sel_ff; // crystal output enable
  logic [1:0] dac_sel_ff; // dac output on p3.2, p2.3
  logic pint03_ff; // interrupt line from p2.3
  logic pint02_ff; // interrupt line from p4.0
  logic can_rx_ff; // can receive input
  logic cec_wake_ff; // stop wakeup request
  logic cec_cap_ff; // consumer-control wake ability

  // decode results
  logic [IDX_W:0] dec_w; // write hit and slot
  logic [IDX_W:0] dec_r; // read hit and slot
  logic wr_fire; // both halves held, answer now
  logic ar_take; // read address taken

  pfs_reg_if rif (); // store access

  // address to hit flag and slot; used for both channels
  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a[1:0] == 2'h0 && a[ADDR_W-1:2] == pfs_pkg::REG_INDEX[i]) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // pads come from outside, two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_meta_ff <= '0;
      pad_sync_ff <= '0;
    end else begin
      pad_meta_ff <= pad_in;
      pad_sync_ff <= pad_meta_ff;
    end
  end

  // register store
  pfs_regfile u_regs (
    .clk(mclk),
    .rst_n(rst_n),
    .rif(rif)
  );

  // write: address and data taken in either order
  assign dec_w = decode(aw_addr_ff);
  assign wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign rif.wr_en = wr_fire & dec_w[IDX_W] & w_lane0_ff;
  assign rif.wr_idx = dec_w[IDX_W-1:0];
  assign rif.wr_data = w_data_ff;

  // write address channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_ff <= 1'b0;
      awready_ff <= 1'b1;
      aw_addr_ff <= '0;
    end else if (axi_awvalid && awready_ff) begin
      // hold address until response taken
      aw_full_ff <= 1'b1;
      awready_ff <= 1'b0;
      aw_addr_ff <= axi_awaddr;
    end else if (bvalid_ff && axi_bready) begin
      // ready for the next write
      aw_full_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_ff <= 1'b0;
      wready_ff <= 1'b1;
      w_data_ff <= '0;
      w_lane0_ff <= 1'b0;
    end else if (axi_wvalid && wready_ff) begin
      // only the low lane carries a select byte
      w_full_ff <= 1'b1;
      wready_ff <= 1'b0;
      w_data_ff <= axi_wdata[7:0];
      w_lane0_ff <= axi_wstrb[0];
    end else if (bvalid_ff && axi_bready) begin
      w_full_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= pfs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      // unmapped address answers slave error
      bvalid_ff <= 1'b1;
      bresp_ff <= dec_w[IDX_W] ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
    end else if (axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read: store reads on the address edge
  assign ar_take = axi_arvalid & arready_ff;
  assign dec_r = decode(axi_araddr);
  assign rif.rd_en = ar_take & dec_r[IDX_W];
  assign rif.rd_idx = dec_r[IDX_W-1:0];

  // read address channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rd_wait_ff <= 1'b0;
      ar_hit_ff <= 1'b0;
    end else if (ar_take) begin
      // one read at a time
      arready_ff <= 1'b0;
      rd_wait_ff <= 1'b1;
      ar_hit_ff <= dec_r[IDX_W];
    end else begin
      rd_wait_ff <= 1'b0;
      if (rvalid_ff && axi_rready) begin
        arready_ff <= 1'b1;
      end
    end
  end

  // read data channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= pfs_pkg::RESP_OKAY;
    end else if (rd_wait_ff) begin
      // byte in low lane, upper bits zero
      rvalid_ff <= 1'b1;
      rdata_ff <= ar_hit_ff ? {24'h000000, rif.rd_data} : 32'h00000000;
      rresp_ff <= ar_hit_ff ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
    end else if (axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // pin cells
  for (genvar p = 0; p < NREG; p++) begin : g_pin
    logic sel_fn; // peripheral owns this pin
    if (p == pfs_pkg::PIN_P3_4) begin : g_ss
      // chip enable gated by slave mode
      assign sel_fn = rif.sel[p][FN] & spi_is_slave;
    end else begin : g_fn
      assign sel_fn = rif.sel[p][FN];
    end
    pfs_pin_cell #(
      .OUT_CAP(pfs_pkg::FN_OUT_CAP[p]),
      .IN_IDLE(pfs_pkg::FN_IN_IDLE[p])
    ) u_cell (
      .clk(mclk),
      .rst_n(rst_n),
      .sel_gpio(rif.sel[p][GIO]),
      .sel_fn(sel_fn),
      .gpio_out(gpio_out[p]),
      .gpio_oe(gpio_oe[p]),
      .fn_out(periph_out[p]),
      .fn_oe(periph_oe[p]),
      .pad_in(pad_sync_ff[p]),
      .pad_out_ff(pad_out[p]),
      .pad_oe_n_ff(pad_oe_n[p]),
      .gpio_in_ff(gpio_in[p]),
      .fn_in_ff(periph_in[p])
    );
  end

  // analog selects and side lines
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_sel_ff <= 1'b0;
      dac_sel_ff <= 2'h0;
      pint03_ff <= pfs_pkg::LINE_IDLE;
      pint02_ff <= pfs_pkg::LINE_IDLE;
      can_rx_ff <= pfs_pkg::LINE_IDLE;
      cec_wake_ff <= 1'b0;
      cec_cap_ff <= 1'b0;
    end else begin
      crystal_sel_ff <= rif.sel[pfs_pkg::PIN_P2_1][FN];
      // dac output enables, pad analog set by software
      dac_sel_ff <= {rif.sel[pfs_pkg::PIN_P3_2][pfs_pkg::VOLTAGE_DAC_OUTPUT_SELECT_BIT],
                     rif.sel[pfs_pkg::PIN_P2_3][pfs_pkg::VOLTAGE_DAC_OUTPUT_SELECT_BIT]};
      // receive pin also drives interrupt line
      pint03_ff <= rif.sel[pfs_pkg::PIN_P2_3][FN] ? pad_sync_ff[pfs_pkg::PIN_P2_3] : pfs_pkg::LINE_IDLE;
      // can receive and its wake interrupt
      if (rif.sel[pfs_pkg::PIN_P4_0][pfs_pkg::CAN_RECEIVE_PIN_SELECT_BIT]) begin
        pint02_ff <= pad_sync_ff[pfs_pkg::PIN_P4_0];
        can_rx_ff <= pad_sync_ff[pfs_pkg::PIN_P4_0];
      end else begin
        pint02_ff <= pfs_pkg::LINE_IDLE;
        can_rx_ff <= pfs_pkg::LINE_IDLE;
      end
      // low on the line requests wake
      cec_wake_ff <= rif.sel[pfs_pkg::PIN_P4_0][pfs_pkg::CONSUMER_CONTROL_WAKE_SELECT_BIT]
                     & ~pad_sync_ff[pfs_pkg::PIN_P4_0];
      cec_cap_ff <= rif.sel[pfs_pkg::PIN_P4_0][FN];
    end
  end

  // outputs straight from flops
  assign axi_awready = awready_ff;
  assign axi_wready = wready_ff;
  assign axi_bvalid = bvalid_ff;
  assign axi_bresp = bresp_ff;
  assign axi_arready = arready_ff;
  assign axi_rvalid = rvalid_ff;
  assign axi_rdata = rdata_ff;
  assign axi_rresp = rresp_ff;
  assign crystal_output_select = crystal_sel_ff;
  assign voltage_dac_output_select = dac_sel_ff;
  assign pin_interrupt_line_0_3 = pint03_ff;
  assign pin_interrupt_line_0_2 = pint02_ff;
  assign can_receive = can_rx_ff;
  assign consumer_control_stop_wake = cec_wake_ff;
  assign consumer_control_wake_capable = cec_cap_ff;

  crystal_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rif.wr_en && rif.wr_idx == IDX_W'(pfs_pkg::PIN_P2_1) && rif.wr_data[FN])
    |=> ##1 crystal_output_select)
    else $error("crystal output not selected two cycles after write");
  rx_interrupt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rif.sel[pfs_pkg::PIN_P2_3][FN]
    |=> pin_interrupt_line_0_3 == $past(pad_sync_ff[pfs_pkg::PIN_P2_3]))
    else $error("interrupt line 0.3 not following receive pin");
  ss_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!spi_is_slave && rif.sel[pfs_pkg::PIN_P3_4][FN]) |=> periph_in[pfs_pkg::PIN_P3_4])
    else $error("chip enable passed while spi is not slave");
  can_rx_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rif.sel[pfs_pkg::PIN_P4_0][pfs_pkg::CAN_RECEIVE_PIN_SELECT_BIT]
    |=> (can_receive == $past(pad_sync_ff[pfs_pkg::PIN_P4_0])) && (pin_interrupt_line_0_2 == can_receive))
    else $error("can receive or interrupt 0.2 not following pin");
  cec_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
    consumer_control_stop_wake |-> !$past(pad_sync_ff[pfs_pkg::PIN_P4_0]))
    else $error("stop wake without low level on line");
  wr_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (axi_awvalid && awready_ff && axi_wvalid && wready_ff) |=> !axi_bvalid ##1 axi_bvalid)
    else $error("write response not two cycles after address and data");
  rd_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ar_take |=> !axi_rvalid ##1 (axi_rvalid && axi_rdata[31:8] == 24'h000000))
    else $error("read answer late or upper bits set");
endmodule

/* File: verif/pfs_far_model.sv */
// far-side model: external pin sources meeting the pad drivers
`timescale 1ns/1ps
module pfs_far_model (
  input wire logic [pfs_pkg::NREG-1:0] pad_out,
  input wire logic [pfs_pkg::NREG-1:0] pad_oe_n,
  input wire logic [pfs_pkg::NREG-1:0] ext_level,
  output logic [pfs_pkg::NREG-1:0] pad_in
);
  // undriven pad shows outside level
  // wire level: the device drive wins, else the external source
  always_comb begin
    for (int i = 0; i < pfs_pkg::NREG; i++) begin
      pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
    end
  end
endmodule

/* File: verif/port2_to_port4_function_select_tb.sv */
// self-checking bench for the pin function-select block
`timescale 1ns/1ps
module port2_to_port4_function_select_tb;
  logic mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, spi_slave, xo, irq3, irq2, canrx, stopw, wakec;
  logic [pfs_pkg::ADDR_W-1:0] awaddr, araddr; // byte addresses
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, dac;
  logic [pfs_pkg::NREG-1:0] pad_in, pad_out, pad_oe_n, g_out, g_oe, g_in, p_out, p_oe, p_in, ext;
  int failures, n_compared;

  pfs_top dut (.mclk(mclk), .nrst(nrst), .axi_awaddr(awaddr), .axi_awvalid(awvalid), .axi_awready(awready),
    .axi_wdata(wdata), .axi_wstrb(wstrb), .axi_wvalid(wvalid), .axi_wready(wready), .axi_bresp(bresp),
    .axi_bvalid(bvalid), .axi_bready(bready), .axi_araddr(araddr), .axi_arvalid(arvalid),
    .axi_arready(arready), .axi_rdata(rdata), .axi_rresp(rresp), .axi_rvalid(rvalid), .axi_rready(rready),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .gpio_out(g_out), .gpio_oe(g_oe),
    .gpio_in(g_in), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in), .spi_is_slave(spi_slave),
    .crystal_output_select(xo), .voltage_dac_output_select(dac), .pin_interrupt_line_0_3(irq3),
    .pin_interrupt_line_0_2(irq2), .can_receive(canrx), .consumer_control_stop_wake(stopw),
    .consumer_control_wake_capable(wakec));
  pfs_far_model far (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext), .pad_in(pad_in));

  // clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // value comparison with mismatch report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // byte address of a slot
  function automatic logic [17:0] adr(input int s);
    return {pfs_pkg::REG_INDEX[s], 2'b00};
  endfunction

  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_pend;
    logic w_pend;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    // each channel released at the edge that takes it; only the watchdog ends a wait
    while (aw_pend || w_pend) begin
      @(posedge mclk);
      if (aw_pend && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_pend && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // bus read
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // write a slot, then let the pad path settle
  task automatic setw(input int s, input logic [7:0] d);
    wr(adr(s), d, resp);
    chk("bresp", pfs_pkg::RESP_OKAY, resp);
    repeat (4) @(posedge mclk);
  endtask

  // counts and verdict
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog, about seven times the expected run of some 1500 cycles
  initial begin
    #1000000;
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; spi_slave = 1'b1;
    g_out = 18'h00002; g_oe = 18'h00002; p_out = 18'h07790; p_oe = 18'h07792; ext = 18'h00048;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("pad_oe_n", 18'h3ffff, pad_oe_n);
    chk("periph_in", pfs_pkg::FN_IN_IDLE, p_in);
    for (int i = 0; i < pfs_pkg::NREG; i++) begin
      rd(adr(i), v, resp);
      chk("reset value", 32'h0, v);
      // one select bit at a time, as software must
      for (int b = 0; b < 8; b++) begin
        wr(adr(i), 8'h01 << b, resp);
        rd(adr(i), v, resp);
        chk("readback", {24'h0, pfs_pkg::REG_MASK[i] & (8'h01 << b)}, v);
      end
      wr(adr(i), 8'h00, resp);
    end
    $display("test registers done");
    wr(18'h00000, 8'h01, resp);
    chk("bresp unmapped", pfs_pkg::RESP_SLVERR, resp);
    rd(18'h00000, v, resp);
    chk("rresp unmapped", pfs_pkg::RESP_SLVERR, resp);
    chk("rdata unmapped", 32'h0, v);
    $display("test unmapped done");
    setw(1, 8'h01);
    chk("gpio oe_n", 1'b0, pad_oe_n[1]);
    chk("gpio out", 1'b1, pad_out[1]);
    setw(6, 8'h01);
    chk("gpio in", 1'b1, g_in[6]);
    setw(1, 8'h02);
    chk("uart tx oe_n", 1'b0, pad_oe_n[1]);
    chk("uart tx out", 1'b0, pad_out[1]);
    setw(2, 8'h02);
    chk("uart rx", 1'b0, p_in[2]);
    chk("irq line 3", 1'b0, irq3);
    setw(2, 8'h80);
    chk("dac select", 2'b01, dac);
    chk("irq line 3 idle", 1'b1, irq3);
    setw(0, 8'h02);
    chk("crystal", 1'b1, xo);
    setw(3, 8'h02);
    chk("timer2 input", 1'b1, p_in[3]);
    setw(11, 8'h02);
    chk("spi chip enable", 1'b0, p_in[11]);
    // spi as master: chip enable pin must not reach the peripheral
    spi_slave <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("spi chip enable gated", 1'b1, p_in[11]);
    setw(16, 8'h02);
    chk("i2c data", 1'b0, p_in[16]);
    setw(15, 8'h08);
    chk("can rx", 1'b0, canrx);
    chk("irq line 2", 1'b0, irq2);
    setw(15, 8'h04);
    chk("stop wake", 1'b1, stopw);
    setw(15, 8'h02);
    chk("wake capable", 1'b1, wakec);
    // peripheral drive reaches the pad: oe_n low, level high
    setw(4, 8'h02);
    chk("timer2 count pin", 2'b01, {pad_oe_n[4], pad_out[4]});
    for (int s = 7; s <= 10; s++) begin
      setw(s, 8'h02);
      chk("capture pin", 2'b01, {pad_oe_n[s], pad_out[s]});
    end
    for (int s = 12; s <= 14; s++) begin
      setw(s, 8'h02);
      chk("spi pin", 2'b01, {pad_oe_n[s], pad_out[s]});
    end
    $display("test routing done");
    finish_test();
  end
endmodule
